// ===== src/general_timer.sv
// General timer: pulse accumulator, port pins, prescaler, input capture
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_map.svh"

module general_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Timer port pins
  input wire logic [3:0] pin_in,
  input wire logic [3:0] compare_level,
  output var general_timer_pkg::port_drive_t pin_drive,
  // Interrupt requests
  output var general_timer_pkg::irq_t irq
);
  import general_timer_pkg::*;

  // Bit 4 marks an address outside the map
  function automatic logic [4:0] reg_idx(input logic [31:0] a);
    reg_idx = {|a[31:6], a[5:2]};
  endfunction

  bus_state_t state_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic [4:0] rd_idx_ff;
  logic [4:0] wr_idx_ff;
  logic wr_ff;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic [4:0] addr_idx;
  logic [7:0] acc_ctrl_ff;
  logic [7:0] scr1_ff;
  logic [2:0] scr2_ff;
  logic [3:0] chan_func_ff;
  logic [3:0] chan_ie_ff;
  logic [7:0] cap_edge_ff;
  logic [3:0] dir_ff;
  logic [3:0] latch_ff;
  logic [15:0] count_ff;
  logic [1:0] acc_flags_ff;
  logic [1:0] nxt_acc_flags;
  logic [3:0] chan_flags_ff;
  logic [3:0] nxt_chan_flags;
  logic [15:0] main_cnt_ff;
  logic [3:0] psc_ff;
  logic [5:0] div64_ff;
  logic [15:0] cap_ff [4];
  logic [3:0] sync0_ff;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] lvl_ff;
  logic [3:0] prev_ff;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] cap_evt;
  logic timer_en;
  logic presc_tick;
  logic div64_tick;
  logic acc_en;
  logic acc_edge;
  logic acc_active_edge;
  logic acc_gate;
  logic acc_inc;
  logic acc_ovf_evt;
  logic acc_in_evt;
  logic count_wr;
  logic fast_clear;

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

  assign addr_idx = reg_idx(haddr);
  assign addr_ok = hsel & hready & htrans[1];
  assign timer_en = scr1_ff[`SCR1_TIMER_EN_BIT];

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= BUS_IDLE;
      hreadyout_ff <= 1'b1;
      rd_idx_ff <= 5'h00;
    end else begin
      unique case (state_ff)
        BUS_IDLE: begin
          if (addr_ok && !hwrite) begin
            state_ff <= BUS_READ;
            hreadyout_ff <= 1'b0;
            rd_idx_ff <= addr_idx;
          end
        end
        BUS_READ: begin
          state_ff <= BUS_IDLE;
          hreadyout_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (state_ff == BUS_READ) begin
      hrdata_ff <= rd_mux;
    end
  end

  // Write data follows in the next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wr_idx_ff <= 5'h00;
    end else begin
      wr_ff <= addr_ok & hwrite;
      wr_idx_ff <= addr_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ctrl_ff <= `ACC_CTRL_RST;
      scr1_ff <= `SCR1_RST;
      scr2_ff <= `SCR2_RST;
      chan_func_ff <= 4'h0;
      chan_ie_ff <= 4'h0;
      cap_edge_ff <= 8'h00;
    end else if (wr_ff) begin
      unique case (wr_idx_ff)
        {1'b0, `IDX_ACCUM_CTRL}: acc_ctrl_ff <= hwdata[7:0] & `ACC_CTRL_MASK;
        {1'b0, `IDX_SYS_CTRL_ONE}: scr1_ff <= hwdata[7:0] & `SCR1_MASK;
        {1'b0, `IDX_SYS_CTRL_TWO}: scr2_ff <= hwdata[2:0];
        {1'b0, `IDX_CHAN_FUNC}: chan_func_ff <= hwdata[3:0];
        {1'b0, `IDX_CHAN_IRQ_EN}: chan_ie_ff <= hwdata[3:0];
        {1'b0, `IDX_CAPTURE_EDGE}: cap_edge_ff <= hwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Reset leaves every pin an input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_ff <= `PORT_DIR_RST;
    end else if (wr_ff && wr_idx_ff == {1'b0, `IDX_PORT_DIR}) begin
      dir_ff <= hwdata[3:0];
    end
  end

  // Data latched regardless of pin use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_ff <= `PORT_LATCH_RST;
    end else if (wr_ff && wr_idx_ff == {1'b0, `IDX_PORT_VALUE}) begin
      latch_ff <= hwdata[3:0];
    end
  end

  // Three stages; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync0_ff <= 4'h0;
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff <= 4'h0;
    end else begin
      sync0_ff <= pin_in;
      sync1_ff <= sync0_ff;
      sync2_ff <= sync1_ff;
      prev_ff <= lvl_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      // Level accepted once two samples agree
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lvl_ff[gi] <= 1'b0;
        end else if (sync1_ff[gi] == sync2_ff[gi]) begin
          lvl_ff[gi] <= sync2_ff[gi];
        end
      end

      assign rise[gi] = lvl_ff[gi] & ~prev_ff[gi];
      assign fall[gi] = ~lvl_ff[gi] & prev_ff[gi];

      // Capture only on input-capture, input-direction pins
      assign cap_evt[gi] = timer_en & ~chan_func_ff[gi] & ~dir_ff[gi] &
        ((cap_edge_ff[2*gi] & rise[gi]) | (cap_edge_ff[2*gi+1] & fall[gi]));

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cap_ff[gi] <= 16'h0000;
        end else if (cap_evt[gi]) begin
          cap_ff[gi] <= main_cnt_ff;
        end
      end
    end
  endgenerate

  // Select zero divides by one, any other by sixteen
  assign presc_tick = (scr2_ff == `PRESC_DIV1_SEL) | (psc_ff == `PRESC16_LAST);
  assign div64_tick = timer_en & (div64_ff == `DIV64_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_ff <= 4'h0;
      div64_ff <= 6'h00;
    end else if (timer_en) begin
      psc_ff <= psc_ff + 4'h1;
      div64_ff <= div64_ff + 6'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_cnt_ff <= 16'h0000;
    end else if (timer_en && presc_tick) begin
      main_cnt_ff <= main_cnt_ff + 16'h0001;
    end
  end

  // Accumulator input shares pin 3
  assign acc_en = acc_ctrl_ff[`ACC_ENABLE_BIT];
  assign acc_edge = acc_ctrl_ff[`ACC_EDGE_BIT];
  assign acc_active_edge = acc_edge ? rise[3] : fall[3];
  assign acc_gate = acc_edge ? ~lvl_ff[3] : lvl_ff[3];
  // Mode picks events or gated time
  assign acc_inc = acc_en & (acc_ctrl_ff[`ACC_MODE_BIT] ? (acc_gate & div64_tick) :
    acc_active_edge);
  // Trailing gate edge equals the selected edge
  assign acc_in_evt = acc_en & acc_active_edge;
  assign count_wr = wr_ff && wr_idx_ff == {1'b0, `IDX_ACCUM_COUNT};
  assign acc_ovf_evt = acc_inc & ~count_wr & (count_ff == `COUNT_MAX);
  // With fast clear set, any count access clears both accumulator flags
  assign fast_clear = scr1_ff[`SCR1_FFCA_BIT] & addr_ok &
    (addr_idx == {1'b0, `IDX_ACCUM_COUNT});

  // Counts synchronised events or gated divide-by-64 ticks; software load wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= `COUNT_RST;
    end else if (count_wr) begin
      count_ff <= hwdata[15:0];
    end else if (acc_inc) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Write-one-to-clear; a new event beats the clear
  always_comb begin
    nxt_acc_flags = acc_flags_ff;
    if (wr_ff && wr_idx_ff == {1'b0, `IDX_ACCUM_FLAGS}) begin
      nxt_acc_flags = nxt_acc_flags & ~hwdata[1:0];
    end
    if (fast_clear) begin
      nxt_acc_flags = 2'b00;
    end
    nxt_acc_flags[`ACC_OVF_BIT] = nxt_acc_flags[`ACC_OVF_BIT] | acc_ovf_evt;
    nxt_acc_flags[`ACC_IN_BIT] = nxt_acc_flags[`ACC_IN_BIT] | acc_in_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_flags_ff <= 2'b00;
    end else begin
      acc_flags_ff <= nxt_acc_flags;
    end
  end

  // Capture sets flag; write one clears, set wins
  always_comb begin
    nxt_chan_flags = chan_flags_ff;
    if (wr_ff && wr_idx_ff == {1'b0, `IDX_CHAN_FLAGS}) begin
      nxt_chan_flags = nxt_chan_flags & ~hwdata[3:0];
    end
    nxt_chan_flags = nxt_chan_flags | cap_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_flags_ff <= 4'h0;
    end else begin
      chan_flags_ff <= nxt_chan_flags;
    end
  end

  // Requests are level, one cycle behind their flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= '0;
    end else begin
      irq.accum_ovf <= acc_flags_ff[`ACC_OVF_BIT] & acc_ctrl_ff[`ACC_OVF_IE_BIT];
      irq.accum_in <= acc_flags_ff[`ACC_IN_BIT] & acc_ctrl_ff[`ACC_IN_IE_BIT];
      irq.channel <= chan_flags_ff & chan_ie_ff;
    end
  end

  // Timer-output pins follow compare logic, not the latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_drive <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (timer_en && chan_func_ff[i]) begin
          pin_drive.oe[i] <= 1'b1;
          pin_drive.level[i] <= compare_level[i];
        end else begin
          // Latch drives only when direction is output
          pin_drive.oe[i] <= dir_ff[i];
          pin_drive.level[i] <= latch_ff[i];
        end
      end
    end
  end

  // Read mux; unmapped and reserved read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_idx_ff)
      {1'b0, `IDX_ACCUM_FLAGS}: rd_mux[1:0] = acc_flags_ff;
      {1'b0, `IDX_ACCUM_COUNT}: rd_mux[15:0] = count_ff;
      // Inputs read pin level, outputs the latch
      {1'b0, `IDX_PORT_VALUE}: rd_mux[3:0] = (dir_ff & latch_ff) | (~dir_ff & lvl_ff);
      {1'b0, `IDX_PORT_DIR}: rd_mux[3:0] = dir_ff;
      {1'b0, `IDX_ACCUM_CTRL}: rd_mux[7:0] = acc_ctrl_ff;
      {1'b0, `IDX_SYS_CTRL_ONE}: rd_mux[7:0] = scr1_ff;
      {1'b0, `IDX_SYS_CTRL_TWO}: rd_mux[2:0] = scr2_ff;
      {1'b0, `IDX_CHAN_FUNC}: rd_mux[3:0] = chan_func_ff;
      {1'b0, `IDX_CHAN_FLAGS}: rd_mux[3:0] = chan_flags_ff;
      {1'b0, `IDX_CHAN_IRQ_EN}: rd_mux[3:0] = chan_ie_ff;
      {1'b0, `IDX_CAPTURE_EDGE}: rd_mux[7:0] = cap_edge_ff;
      {1'b0, `IDX_MAIN_COUNT}: rd_mux[15:0] = main_cnt_ff;
      5'h0C: rd_mux[15:0] = cap_ff[0];
      5'h0D: rd_mux[15:0] = cap_ff[1];
      5'h0E: rd_mux[15:0] = cap_ff[2];
      5'h0F: rd_mux[15:0] = cap_ff[3];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

endmodule // general_timer
`default_nettype wire

// ===== src/general_timer_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GENERAL_TIMER_MAP_SVH
`define GENERAL_TIMER_MAP_SVH

// Register word indices (byte address = 4 * index)
`define IDX_ACCUM_FLAGS 4'h0
`define IDX_ACCUM_COUNT 4'h1
`define IDX_PORT_VALUE 4'h2
`define IDX_PORT_DIR 4'h3
`define IDX_ACCUM_CTRL 4'h4
`define IDX_SYS_CTRL_ONE 4'h5
`define IDX_SYS_CTRL_TWO 4'h6
`define IDX_CHAN_FUNC 4'h7
`define IDX_CHAN_FLAGS 4'h8
`define IDX_CHAN_IRQ_EN 4'h9
`define IDX_CAPTURE_EDGE 4'hA
`define IDX_MAIN_COUNT 4'hB
`define IDX_CAPTURE_BASE 4'hC

// Accumulator flag fields
`define ACC_OVF_BIT 1
`define ACC_IN_BIT 0

// Accumulator control fields
`define ACC_ENABLE_BIT 6
`define ACC_MODE_BIT 5
`define ACC_EDGE_BIT 4
`define ACC_OVF_IE_BIT 1
`define ACC_IN_IE_BIT 0
`define ACC_CTRL_MASK 8'h73

// System control one fields
`define SCR1_TIMER_EN_BIT 7
`define SCR1_FFCA_BIT 4
`define SCR1_MASK 8'h90

// Reset values
`define ACC_CTRL_RST 8'h00
`define SCR1_RST 8'h00
`define SCR2_RST 3'h0
`define PORT_DIR_RST 4'h0
`define PORT_LATCH_RST 4'h0
`define COUNT_RST 16'h0000

// Timing counts in module clocks
`define PRESC_DIV1_SEL 3'h0
`define PRESC16_LAST 4'hF
`define DIV64_LAST 6'h3F
`define COUNT_MAX 16'hFFFF

`endif

// ===== src/general_timer_pkg.sv
// Types shared by the general timer block
package general_timer_pkg;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } port_drive_t;

  typedef struct packed {
    logic accum_ovf;
    logic accum_in;
    logic [3:0] channel;
  } irq_t;

endpackage

// ===== verif/timer_checker_assertions.sv
// Bus and pin checks for the general timer
`timescale 1ns/1ps
`default_nettype none
module timer_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Pins and requests
  input wire logic [3:0] pin_in,
  input wire general_timer_pkg::port_drive_t pin_drive,
  input wire general_timer_pkg::irq_t irq
);
  import general_timer_pkg::*;
  logic take;
  logic wph_ff;
  logic [3:0] quiet_ff;
  assign take = hsel & hready & htrans[1];
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Write data phase in flight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wph_ff <= 1'b0;
    else wph_ff <= take & hwrite;
  end
  // Cycles since a pin moved, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_ff <= 4'hF;
    else if ($changed(pin_in)) quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
  end
  rst_state_a: assert property (
    $rose(hresetn) |-> pin_drive.oe == 4'h0 && irq == '0 && hreadyout)
    else $error("state after reset wrong");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read without one wait");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  one_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait longer than one cycle");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside a read");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  // Drive enable only moves after a register write
  dir_cause_a: assert property (
    $changed(pin_drive.oe) |-> $past(wph_ff) || $past(wph_ff, 2))
    else $error("drive enable moved without a write");
  // Input and capture requests rise only after a pin event or a write
  // Overflow left out: gated counting can wrap long after the last pin move
  irq_cause_a: assert property (
    $rose(irq.accum_in || (|irq.channel)) |-> quiet_ff < 4'hC || $past(wph_ff) ||
      $past(wph_ff, 2))
    else $error("request rose without cause");
  read_c: cover property (take && !hwrite);
  ovf_c: cover property ($rose(irq.accum_ovf));
  cap_c: cover property ($rose(irq.channel[0]));
endmodule // timer_checker
`default_nettype wire

// ===== verif/pin_partner.sv
// Pin sources and loads facing the timer port
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Clock
  input wire logic hclk,
  // Pins
  input wire general_timer_pkg::port_drive_t pin_drive,
  output logic [3:0] pin_in
);
  import general_timer_pkg::*;
  logic [3:0] ext_ff = 4'h0;
  // Driven pins show the timer, others the outside source
  assign pin_in = (pin_drive.oe & pin_drive.level) | (~pin_drive.oe & ext_ff);
  task automatic set_level(input logic [3:0] v);
    @(posedge hclk);
    ext_ff <= v;
  endtask
  task automatic pulse(input int b);
    @(posedge hclk);
    ext_ff[b] <= ~ext_ff[b];
    repeat (4) @(posedge hclk);
    ext_ff[b] <= ~ext_ff[b];
  endtask
endmodule // pin_partner
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the general timer
`timescale 1ns/1ps
`default_nettype none
`include "general_timer_map.svh"
module tb;
  import general_timer_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] wd; logic [31:0] exp;} row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] cmp_lvl = 4'hF;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata, rd, m0, m1;
  logic [3:0] pin_in;
  port_drive_t pin_drive;
  irq_t irq;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  row_t rows [5] = '{
    '{32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_000F},
    '{32'h0000_0008, 32'h0000_00A5, 32'h0000_0005},
    '{32'h0000_0004, 32'hABCD_1234, 32'h0000_1234},
    '{32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0073},
    '{32'h0000_0040, 32'hFFFF_FFFF, 32'h0000_0000}};
  general_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_in,
    .compare_level(cmp_lvl), .pin_drive, .irq);
  pin_partner pins (.hclk, .pin_drive, .pin_in);
  always #2.5 hclk = ~hclk;
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic reg_wr(input logic [3:0] i, input logic [31:0] d);
    bus(1'b1, {26'h0, i, 2'h0}, d);
  endtask
  // Whole-word reads only
  task automatic reg_rd(input logic [3:0] i);
    bus(1'b0, {26'h0, i, 2'h0}, 32'h0);
  endtask
  task automatic cw(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    reg_rd(`IDX_PORT_DIR);
    cw(rd, 32'h0);
    cp(pin_drive.oe, 4'h0);
    $display("done: reset");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].wd);
      bus(1'b0, rows[i].a, 32'h0);
      cw(rd, rows[i].exp);
    end
    repeat (3) @(posedge hclk);
    cp(pin_drive.oe, 4'hF);
    cp(pin_drive.level, 4'h5);
    $display("done: rows");
    reg_wr(`IDX_PORT_DIR, 32'h0);
    pins.set_level(4'hA);
    repeat (6) @(posedge hclk);
    reg_rd(`IDX_PORT_VALUE);
    cw(rd, 32'h0000_000A);
    pins.set_level(4'h0);
    $display("done: port input");
    reg_wr(`IDX_ACCUM_CTRL, 32'h0000_0053);
    reg_wr(`IDX_ACCUM_FLAGS, 32'h0000_0003);
    reg_wr(`IDX_ACCUM_COUNT, 32'h0000_FFFF);
    pins.pulse(3);
    repeat (12) @(posedge hclk);
    reg_rd(`IDX_ACCUM_COUNT);
    cw(rd, 32'h0);
    reg_rd(`IDX_ACCUM_FLAGS);
    cw(rd, 32'h0000_0003);
    cp({2'h0, irq.accum_ovf, irq.accum_in}, 4'h3);
    reg_wr(`IDX_ACCUM_FLAGS, 32'h0000_0001);
    reg_rd(`IDX_ACCUM_FLAGS);
    cw(rd, 32'h0000_0002);
    cp({2'h0, irq.accum_ovf, irq.accum_in}, 4'h2);
    reg_wr(`IDX_ACCUM_CTRL, 32'h0000_0043);
    pins.pulse(3);
    repeat (12) @(posedge hclk);
    reg_rd(`IDX_ACCUM_COUNT);
    cw(rd, 32'h0000_0001);
    $display("done: accumulator");
    reg_wr(`IDX_SYS_CTRL_ONE, 32'h0000_0010);
    reg_rd(`IDX_ACCUM_COUNT);
    reg_rd(`IDX_ACCUM_FLAGS);
    cw(rd, 32'h0);
    cp({2'h0, irq.accum_ovf, irq.accum_in}, 4'h0);
    $display("done: fast clear");
    reg_wr(`IDX_SYS_CTRL_ONE, 32'h0000_0080);
    reg_wr(`IDX_CAPTURE_EDGE, 32'h0000_0005);
    reg_wr(`IDX_CHAN_IRQ_EN, 32'h0000_0001);
    reg_wr(`IDX_PORT_DIR, 32'h0000_0002);
    reg_rd(`IDX_MAIN_COUNT);
    m0 = rd;
    pins.pulse(0);
    reg_wr(`IDX_PORT_VALUE, 32'h0000_0002);
    repeat (12) @(posedge hclk);
    reg_rd(`IDX_MAIN_COUNT);
    m1 = rd;
    reg_rd(`IDX_CHAN_FLAGS);
    cw(rd, 32'h0000_0001);
    cp(irq.channel, 4'h1);
    reg_rd(`IDX_CAPTURE_BASE);
    cp({3'h0, rd[15:0] > m0[15:0] && rd[15:0] < m1[15:0]}, 4'h1);
    reg_rd(`IDX_PORT_DIR);
    cw(rd, 32'h0000_0002);
    $display("done: capture");
    reg_wr(`IDX_CHAN_FUNC, 32'h0000_0001);
    reg_wr(`IDX_PORT_DIR, 32'h0000_0003);
    reg_wr(`IDX_PORT_VALUE, 32'h0);
    repeat (3) @(posedge hclk);
    cp(pin_drive.level & 4'h3, 4'h1);
    reg_rd(`IDX_PORT_VALUE);
    cw(rd, 32'h0);
    $display("done: compare pin");
    for (int s = 0; s < 2; s++) begin
      reg_wr(`IDX_SYS_CTRL_TWO, {31'h0, ~s[0]});
      reg_rd(`IDX_MAIN_COUNT);
      m0 = rd;
      repeat (64) @(posedge hclk);
      reg_rd(`IDX_MAIN_COUNT);
      cp({3'h0, (rd[15:0] - m0[15:0]) > 16'h0010}, {3'h0, s[0]});
    end
    $display("done: prescaler");
    reg_wr(`IDX_ACCUM_CTRL, 32'h0000_0060);
    reg_wr(`IDX_CAPTURE_EDGE, 32'h0000_0080);
    reg_wr(`IDX_ACCUM_COUNT, 32'h0);
    reg_wr(`IDX_ACCUM_FLAGS, 32'h0000_0003);
    // Gate open for 257 cycles, so four or five divide-by-64 ticks
    pins.set_level(4'h8);
    repeat (256) @(posedge hclk);
    pins.set_level(4'h0);
    repeat (6) @(posedge hclk);
    reg_rd(`IDX_ACCUM_COUNT);
    cp({3'h0, rd == 32'h4 || rd == 32'h5}, 4'h1);
    reg_rd(`IDX_ACCUM_FLAGS);
    cw(rd, 32'h0000_0001);
    reg_rd(`IDX_CHAN_FLAGS);
    cw(rd, 32'h0000_0009);
    $display("done: gated");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    reg_rd(`IDX_ACCUM_COUNT);
    cw(rd, 32'h0);
    reg_rd(`IDX_PORT_DIR);
    cw(rd, 32'h0);
    cp(pin_drive.oe, 4'h0);
    $display("done: mid reset");
    stop_test();
  end
endmodule // tb
bind general_timer timer_checker chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .pin_in, .pin_drive, .irq);
`default_nettype wire
